// file: shared/sep_pkg.sv
// sep_pkg: shared constants and types of the scan engine host pin block.
// assumes a single 10 MHz core clock and an apb register port.
package sep_pkg;
    // clock and timing
    localparam int unsigned CLK_PERIOD_NS    = 100;       // core clock period
    localparam int unsigned CLK_HZ           = 10_000_000; // core clock rate
    localparam int unsigned BAUD_RATE        = 9600;      // serial bit rate, bits per second
    localparam int unsigned BIT_CYC          = CLK_HZ / BAUD_RATE; // longest whole count
    localparam int unsigned SLEEP_TIMEOUT_MS = 1000;      // idle time before power-down
    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00; // control
    localparam logic [7:0] OFS_STAT = 8'h04; // status, read only
    localparam logic [7:0] OFS_TXD  = 8'h08; // transmit byte, write only
    localparam logic [7:0] OFS_RXD  = 8'h0c; // receive byte, read clears valid
    localparam logic [7:0] OFS_BUZ  = 8'h10; // buzzer period and duty
    // status bit positions
    localparam int unsigned ST_DL    = 0; // download mode strap
    localparam int unsigned ST_VBUS  = 1; // bus power present
    localparam int unsigned ST_SLEEP = 2; // powered down
    localparam int unsigned ST_SCAN  = 3; // scan running
    localparam int unsigned ST_RXV   = 4; // receive byte waiting
    localparam int unsigned ST_FULL  = 5; // transmit fifo full
    localparam int unsigned ST_EMPTY = 6; // transmit fifo empty
    localparam int unsigned ST_TRIG  = 7; // trigger held
    // fifo shape
    localparam int unsigned TXF_WIDTH = 8;
    localparam int unsigned TXF_DEPTH = 16;
    // control register layout, top bit first
    typedef struct packed {
        logic [26:0] rsvd;      // reads zero
        logic        buz_en;    // bit 4: buzzer on
        logic        ext_light; // bit 3: external light on
        logic        good_read; // bit 2: good read lamp on
        logic        aim_int;   // bit 1: aim leds during scan
        logic        sleep_en;  // bit 0: power-down mode configured
    } sep_ctrl_s;
    localparam sep_ctrl_s CTRL_RST = '{rsvd: '0, sleep_en: 1'b1, default: 1'b0};
    // buzzer waveform
    typedef struct packed {
        logic [15:0] duty;   // high cycles per period
        logic [15:0] period; // period in cycles minus one
    } sep_buz_s;
    localparam sep_buz_s BUZ_RST = '{duty: 16'h0000, period: 16'h0000};
    // power modes
    typedef enum logic [1:0] {
        PM_SLEEP,
        PM_STANDBY,
        PM_SCAN
    } sep_pwr_e;
endpackage : sep_pkg

// file: logic/sep_fifo.sv
// sep_fifo: flip-flop fifo with valid/ready on both sides.
// assumes one clock; both sides may act in the same cycle.
`timescale 1ns/1ns
module sep_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 16
) (
    input  wire logic             core_clk_i,
    input  wire logic             rst_n_i,
    input  wire logic             in_valid_i, // producer has a word
    output logic                  in_ready_o, // room for a word
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o, // word available
    input  wire logic             out_ready_i, // consumer takes it
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int unsigned AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH]; // storage
    logic [AW:0]      wp_r;          // write pointer with wrap bit
    logic [AW:0]      rp_r;          // read pointer with wrap bit
    logic [AW:0]      wp_nxt;
    logic [AW:0]      rp_nxt;
    logic             push;
    logic             pop;

    // full when pointers differ only in wrap bit
    always_comb begin
        in_ready_o  = (wp_r[AW-1:0] != rp_r[AW-1:0]) || (wp_r[AW] == rp_r[AW]);
        out_valid_o = (wp_r != rp_r);
        out_data_o  = mem_r[rp_r[AW-1:0]];
        push        = in_valid_i && in_ready_o;
        pop         = out_valid_o && out_ready_i;
        wp_nxt      = push ? wp_r + 1'b1 : wp_r;
        rp_nxt      = pop ? rp_r + 1'b1 : rp_r;
    end

    // pointers and storage
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wp_r <= '0;
            rp_r <= '0;
        end else begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
            if (push) begin
                mem_r[wp_r[AW-1:0]] <= in_data_i;
            end
        end
    end
endmodule : sep_fifo

// file: logic/sep_host_pins.sv
// sep_host_pins: host pin logic of the scan engine, apb register port.
// assumes all pins synchronous to core_clk_i and a single apb master.
// Behaviour
// - download strap sampled right after power-up
// - serial bytes out on txd, in on rxd
// - rts requests output while data waits
// - buzzer is pwm with period and duty
// - aim pin drives aim leds in standby; aim_int bit drives them during scan
// - trigger low starts scan, high idles
// - external light output low means on
// - bus power sense readable in status
// - cts high or aim low wakes from power-down
// - auto power-down at boot and after timeout
`timescale 1ns/1ns
module sep_host_pins
    import sep_pkg::*;
#(
    parameter int unsigned SLEEP_CYC = SLEEP_TIMEOUT_MS * (CLK_HZ / 1000) // idle cycles, no overflow
) (
    input  wire logic        core_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        download_select_n_i, // strap, low = download
    input  wire logic        rxd_i,               // serial in, idle high
    output logic             txd_o,               // serial out, idle high
    input  wire logic        cts_i,               // host allows output
    output logic             rts_o,               // device wants to output
    output logic             sleep_indicator_o,   // high while down
    output logic             buzzer_o,            // pwm tone
    output logic             good_read_lamp_n_o,  // low = lamp on
    input  wire logic        aim_wake_n_i,        // aim or wake, low active
    output logic             aim_led_o,           // aim leds on
    input  wire logic        scan_trigger_n_i,    // low = scan
    output logic             scan_active_o,       // scan running
    output logic             ext_light_on_n_o,    // low = light on
    input  wire logic        bus_power_sense_i    // usb bus power present
);
    // register port
    sep_ctrl_s   ctrl_r;     // control
    sep_ctrl_s   ctrl_nxt;
    sep_buz_s    buz_r;      // buzzer setting
    sep_buz_s    buz_nxt;
    logic        acc;        // access phase
    logic        hit_ok;     // mapped address
    logic        txf_ready;  // fifo room
    logic        txf_valid;  // fifo has a byte
    logic [7:0]  txf_data;
    logic        tx_go;      // transmitter takes a byte
    logic        tx_push;    // apb write into fifo
    logic        rx_rd;      // software reads rx byte
    logic        rx_done;    // receiver finished a byte
    logic [7:0]  rx_data_r;  // last received byte
    logic [7:0]  rx_data_nxt;
    logic        rx_v_r;     // received byte waiting
    logic        rx_v_nxt;
    logic        dl_r;       // download mode latched
    logic        dl_nxt;
    logic        boot_r;     // first cycle after reset
    sep_pwr_e    pm_r;       // power mode
    sep_pwr_e    pm_nxt;
    logic [31:0] idle_r;     // idle counter
    logic [31:0] idle_nxt;
    // serial state, declared early: power modes and register writes read it
    logic        tx_busy_r;  // frame in flight
    logic        tx_busy_nxt;
    logic [9:0]  tx_sh_r;    // stop, data, start; lsb first
    logic [9:0]  tx_sh_nxt;
    logic [3:0]  tx_bit_r;   // bits left
    logic [3:0]  tx_bit_nxt;
    logic [15:0] tx_cnt_r;   // baud counter
    logic [15:0] tx_cnt_nxt;
    logic        rx_busy_r;  // frame being sampled
    logic        rx_busy_nxt;
    logic [7:0]  rx_shift_r; // assembled byte
    logic [7:0]  rx_shift_nxt;
    logic [3:0]  rx_bit_r;   // samples left
    logic [3:0]  rx_bit_nxt;
    logic [15:0] rx_cnt_r;   // baud counter
    logic [15:0] rx_cnt_nxt;

    // address decode and pready; a full fifo stalls the write
    always_comb begin
        acc    = psel && penable;
        hit_ok = 1'b0;
        if (paddr == OFS_CTRL) begin
            hit_ok = 1'b1;
        end else if (paddr == OFS_STAT) begin
            hit_ok = 1'b1;
        end else if (paddr == OFS_TXD) begin
            hit_ok = 1'b1;
        end else if (paddr == OFS_RXD) begin
            hit_ok = 1'b1;
        end else if (paddr == OFS_BUZ) begin
            hit_ok = 1'b1;
        end
        pready  = !(pwrite && paddr == OFS_TXD && !txf_ready); // back-pressure
        pslverr = acc && !hit_ok;
        tx_push = acc && pwrite && paddr == OFS_TXD;
        rx_rd   = acc && pready && !pwrite && paddr == OFS_RXD;
    end

    // read mux, unmapped reads zero
    always_comb begin
        prdata = 32'h0000_0000;
        if (paddr == OFS_CTRL) begin
            prdata = ctrl_r;
        end else if (paddr == OFS_STAT) begin
            prdata[ST_DL]    = dl_r;
            prdata[ST_VBUS]  = bus_power_sense_i;
            prdata[ST_SLEEP] = (pm_r == PM_SLEEP);
            prdata[ST_SCAN]  = (pm_r == PM_SCAN);
            prdata[ST_RXV]   = rx_v_r;
            prdata[ST_FULL]  = !txf_ready;
            prdata[ST_EMPTY] = !txf_valid;
            prdata[ST_TRIG]  = !scan_trigger_n_i;
        end else if (paddr == OFS_RXD) begin
            prdata[7:0] = rx_data_r;
        end else if (paddr == OFS_BUZ) begin
            prdata = buz_r;
        end
    end

    // register writes and receive flag; a new byte wins over the read clear
    always_comb begin
        ctrl_nxt    = ctrl_r;
        buz_nxt     = buz_r;
        rx_v_nxt    = rx_v_r;
        rx_data_nxt = rx_data_r;
        if (acc && pwrite && paddr == OFS_CTRL) begin
            ctrl_nxt      = pwdata;
            ctrl_nxt.rsvd = '0;
        end else if (acc && pwrite && paddr == OFS_BUZ) begin
            buz_nxt = pwdata;
        end
        if (rx_rd) begin
            rx_v_nxt = 1'b0;
        end
        if (rx_done) begin
            rx_v_nxt    = 1'b1;
            rx_data_nxt = rx_shift_r;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_r    <= CTRL_RST;
            buz_r     <= BUZ_RST;
            rx_v_r    <= 1'b0;
            rx_data_r <= 8'h00;
        end else begin
            ctrl_r    <= ctrl_nxt;
            buz_r     <= buz_nxt;
            rx_v_r    <= rx_v_nxt;
            rx_data_r <= rx_data_nxt;
        end
    end

    // transmit buffer; the uart drains it only while cts allows
    sep_fifo #(.WIDTH(TXF_WIDTH), .DEPTH(TXF_DEPTH)) u_txf (
        .core_clk_i  (core_clk_i),
        .rst_n_i     (rst_n_i),
        .in_valid_i  (tx_push),
        .in_ready_o  (txf_ready),
        .in_data_i   (pwdata[7:0]),
        .out_valid_o (txf_valid),
        .out_ready_i (tx_go),
        .out_data_o  (txf_data)
    );

    // power modes
    // strap caught on the first clock after release, never in reset
    always_comb begin
        dl_nxt   = boot_r ? !download_select_n_i : dl_r;
        pm_nxt   = pm_r;
        idle_nxt = 32'h0000_0000;
        case (pm_r)
            PM_SLEEP: begin
                if (cts_i || !aim_wake_n_i) begin
                    pm_nxt = PM_STANDBY;
                end
            end
            PM_STANDBY: begin
                if (boot_r && ctrl_r.sleep_en) begin
                    pm_nxt = PM_SLEEP;
                end else if (!scan_trigger_n_i) begin
                    pm_nxt = PM_SCAN;
                end else if (cts_i || !aim_wake_n_i || !rxd_i || txf_valid || tx_busy_r) begin
                    idle_nxt = 32'h0000_0000; // activity restarts the wait
                end else if (ctrl_r.sleep_en && idle_r >= SLEEP_CYC - 1) begin
                    pm_nxt = PM_SLEEP;
                end else begin
                    idle_nxt = idle_r + 1'b1;
                end
            end
            default: begin
                if (scan_trigger_n_i) begin
                    pm_nxt = PM_STANDBY;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            boot_r <= 1'b1;
            dl_r   <= 1'b0;
            pm_r   <= PM_STANDBY;
            idle_r <= 32'h0000_0000;
        end else begin
            boot_r <= 1'b0;
            dl_r   <= dl_nxt;
            pm_r   <= pm_nxt;
            idle_r <= idle_nxt;
        end
    end

    // serial transmit

    // a byte leaves only with cts high at the start bit
    always_comb begin
        tx_go       = !tx_busy_r && txf_valid && cts_i;
        tx_busy_nxt = tx_busy_r;
        tx_sh_nxt   = tx_sh_r;
        tx_bit_nxt  = tx_bit_r;
        tx_cnt_nxt  = tx_cnt_r;
        if (tx_go) begin
            tx_busy_nxt = 1'b1;
            tx_sh_nxt   = {1'b1, txf_data, 1'b0};
            tx_bit_nxt  = 4'ha;
            tx_cnt_nxt  = 16'(BIT_CYC - 1);
        end else if (tx_busy_r && tx_cnt_r != 16'h0000) begin
            tx_cnt_nxt = tx_cnt_r - 1'b1;
        end else if (tx_busy_r) begin
            tx_sh_nxt   = {1'b1, tx_sh_r[9:1]};
            tx_bit_nxt  = tx_bit_r - 1'b1;
            tx_cnt_nxt  = 16'(BIT_CYC - 1);
            tx_busy_nxt = (tx_bit_r != 4'h1);
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_busy_r <= 1'b0;
            tx_sh_r   <= 10'h3ff;
            tx_bit_r  <= 4'h0;
            tx_cnt_r  <= 16'h0000;
        end else begin
            tx_busy_r <= tx_busy_nxt;
            tx_sh_r   <= tx_sh_nxt;
            tx_bit_r  <= tx_bit_nxt;
            tx_cnt_r  <= tx_cnt_nxt;
        end
    end

    // serial receive

    // half a bit to the start bit centre, then one bit per sample
    always_comb begin
        rx_busy_nxt  = rx_busy_r;
        rx_shift_nxt = rx_shift_r;
        rx_bit_nxt   = rx_bit_r;
        rx_cnt_nxt   = rx_cnt_r;
        rx_done      = 1'b0;
        if (!rx_busy_r && !rxd_i) begin
            rx_busy_nxt = 1'b1;
            rx_bit_nxt  = 4'h9;
            rx_cnt_nxt  = 16'(BIT_CYC / 2);
        end else if (rx_busy_r && rx_cnt_r != 16'h0000) begin
            rx_cnt_nxt = rx_cnt_r - 1'b1;
        end else if (rx_busy_r) begin
            rx_cnt_nxt = 16'(BIT_CYC - 1);
            rx_bit_nxt = rx_bit_r - 1'b1;
            if (rx_bit_r == 4'h9 && rxd_i) begin
                rx_busy_nxt = 1'b0; // glitch, not a start bit
            end else if (rx_bit_r == 4'h0) begin
                rx_busy_nxt = 1'b0;
                rx_done     = rxd_i; // bad stop bit drops the byte
            end else if (rx_bit_r != 4'h9) begin
                rx_shift_nxt = {rxd_i, rx_shift_r[7:1]};
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rx_busy_r  <= 1'b0;
            rx_shift_r <= 8'h00;
            rx_bit_r   <= 4'h0;
            rx_cnt_r   <= 16'h0000;
        end else begin
            rx_busy_r  <= rx_busy_nxt;
            rx_shift_r <= rx_shift_nxt;
            rx_bit_r   <= rx_bit_nxt;
            rx_cnt_r   <= rx_cnt_nxt;
        end
    end

    // buzzer
    logic [15:0] buz_cnt_r;  // position in period
    logic [15:0] buz_cnt_nxt;
    logic        tone_r;     // registered tone
    logic        tone_nxt;

    // duty beyond period gives a steady level
    always_comb begin
        buz_cnt_nxt = (buz_cnt_r >= buz_r.period) ? 16'h0000 : buz_cnt_r + 1'b1;
        tone_nxt    = ctrl_r.buz_en && pm_r != PM_SLEEP && buz_cnt_r < buz_r.duty;
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            buz_cnt_r <= 16'h0000;
            tone_r    <= 1'b0;
        end else begin
            buz_cnt_r <= buz_cnt_nxt;
            tone_r    <= tone_nxt;
        end
    end

    // pin outputs
    // lamps go dark while down to save current
    always_comb begin
        txd_o              = tx_sh_r[0];
        rts_o              = txf_valid || tx_busy_r;
        buzzer_o           = tone_r;
        sleep_indicator_o  = (pm_r == PM_SLEEP);
        scan_active_o      = (pm_r == PM_SCAN);
        good_read_lamp_n_o = !(ctrl_r.good_read && pm_r != PM_SLEEP);
        ext_light_on_n_o   = !(ctrl_r.ext_light && pm_r != PM_SLEEP);
        aim_led_o          = 1'b0;
        if (pm_r == PM_SCAN) begin
            aim_led_o = ctrl_r.aim_int;
        end else if (pm_r == PM_STANDBY) begin
            aim_led_o = !aim_wake_n_i;
        end
    end

    // checks
    sequence s_tx_go;
        !tx_busy_r ##1 tx_busy_r;
    endsequence
    property p_strap;
        @(posedge core_clk_i) disable iff (!rst_n_i) boot_r |=> dl_r == !$past(download_select_n_i);
    endproperty
    a_strap: assert property (p_strap) else $error("strap not latched");
    property p_cts;
        @(posedge core_clk_i) disable iff (!rst_n_i) s_tx_go |-> $past(cts_i) && !txd_o;
    endproperty
    a_cts: assert property (p_cts) else $error("byte sent without cts");
    property p_rts;
        @(posedge core_clk_i) disable iff (!rst_n_i) tx_push && pready |=> rts_o;
    endproperty
    a_rts: assert property (p_rts) else $error("rts not raised");
    property p_buz;
        @(posedge core_clk_i) disable iff (!rst_n_i)
            ctrl_r.buz_en && pm_r == PM_STANDBY && buz_cnt_r >= buz_r.duty |=> !buzzer_o;
    endproperty
    a_buz: assert property (p_buz) else $error("buzzer high past duty");
    property p_aim;
        @(posedge core_clk_i) disable iff (!rst_n_i) pm_r == PM_SLEEP |-> !aim_led_o;
    endproperty
    a_aim: assert property (p_aim) else $error("aim lit while down");
    property p_trig;
        @(posedge core_clk_i) disable iff (!rst_n_i)
            pm_r == PM_STANDBY && !boot_r && !scan_trigger_n_i |=> scan_active_o;
    endproperty
    a_trig: assert property (p_trig) else $error("trigger ignored");
    property p_light;
        @(posedge core_clk_i) disable iff (!rst_n_i)
            !sleep_indicator_o && ctrl_r.ext_light |-> !ext_light_on_n_o;
    endproperty
    a_light: assert property (p_light) else $error("light output wrong");
    property p_wake;
        @(posedge core_clk_i) disable iff (!rst_n_i) sleep_indicator_o && cts_i |=> !sleep_indicator_o;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake on cts");
    property p_boot;
        @(posedge core_clk_i) disable iff (!rst_n_i) boot_r && ctrl_r.sleep_en |=> sleep_indicator_o;
    endproperty
    a_boot: assert property (p_boot) else $error("no power-down at boot");
endmodule : sep_host_pins

// file: sim/sep_host_model.sv
// sep_host_model: host side of the serial pair, 8n1 at the package bit rate.
// assumes core_clk_i is the device clock; the bench sets allow_i for cts.
`timescale 1ns/1ns
module sep_host_model
    import sep_pkg::*;
(
    input  wire logic core_clk_i,
    input  wire logic txd_i,    // device serial out
    input  wire logic allow_i,  // bench permits device output
    output logic      rxd_o,    // serial into the device, idle high
    output logic      cts_o     // permission, active high
);
    logic [7:0] got[$];  // bytes taken from the device
    logic [7:0] sh;      // receive shift
    initial begin
        rxd_o = 1'b1;
        cts_o = 1'b0;
    end
    // host grants output only when told to, so stalls are real
    always @(posedge core_clk_i) cts_o <= allow_i;
    // receiver: mid-bit sampling, lsb first, stop must be high
    always begin
        @(negedge txd_i);
        repeat (BIT_CYC / 2) @(posedge core_clk_i);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYC) @(posedge core_clk_i);
            sh[i] = txd_i;
        end
        repeat (BIT_CYC) @(posedge core_clk_i);
        if (txd_i === 1'b1) got.push_back(sh);
    end
    // sender: start, eight data bits lsb first, stop
    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge core_clk_i);
            rxd_o <= f[i];
            repeat (BIT_CYC - 1) @(posedge core_clk_i);
        end
    endtask : send
endmodule : sep_host_model

// file: sim/scan_engine_host_pins_bench.sv
// scan_engine_host_pins_bench: self-checking bench of sep_host_pins.
// assumes sep_host_model on the serial pair and a short sleep timeout.
`timescale 1ns/1ns
module scan_engine_host_pins_bench;
    import sep_pkg::*;
    logic        core_clk_i = 1'b0, rst_n_i = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdat, v, cnt;
    logic        pready, pslverr, rerr, txd, rts, rxd, cts, allow = 1'b0;
    logic        dl = 1'b1, aim_n = 1'b1, trig_n = 1'b1, vbus = 1'b0;
    logic        sleep, buz, lamp_n, aim, scan, light_n;
    logic [7:0]  b[16];
    int          n_fail = 0, n_tests = 0, n, d;

    always #50 core_clk_i = ~core_clk_i; // 10 mhz

    // short idle timeout keeps the power-down test quick
    sep_host_pins #(.SLEEP_CYC(50)) i_dut (
        .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .download_select_n_i(dl), .rxd_i(rxd),
        .txd_o(txd), .cts_i(cts), .rts_o(rts), .sleep_indicator_o(sleep),
        .buzzer_o(buz), .good_read_lamp_n_o(lamp_n), .aim_wake_n_i(aim_n),
        .aim_led_o(aim), .scan_trigger_n_i(trig_n), .scan_active_o(scan),
        .ext_light_on_n_o(light_n), .bus_power_sense_i(vbus));
    sep_host_model i_host (.core_clk_i(core_clk_i), .txd_i(txd), .allow_i(allow),
        .rxd_o(rxd), .cts_o(cts));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
            n_fail++;
        end
    endtask : check
    // one apb transfer; waits for pready, result in rdat and rerr
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] dd);
        int k;
        @(posedge core_clk_i);
        psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= dd;
        @(posedge core_clk_i);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge core_clk_i);
            k++;
        end while (pready !== 1'b1 && k < 30000);
        if (pready !== 1'b1) begin
            n_fail++; // a stalled bus counts as a mismatch
        end
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb
    task automatic tick(input int c);
        repeat (c) @(posedge core_clk_i);
    endtask : tick
    // pwm highs over whole periods: duty cycles in each period
    function automatic logic [31:0] buz_highs(input int duty, input int periods);
        return 32'(duty * periods);
    endfunction : buz_highs
    task automatic summarize;
        $display("tests %0d failures %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : summarize

    // watchdog: the serial frames need about 31k cycles
    initial begin
        tick(80000);
        n_fail++;
        summarize();
    end

    initial begin
        void'($urandom(11));
        dl = 1'($urandom_range(0, 1));
        tick(10);
        rst_n_i <= 1'b1;
        tick(2);
        check(sleep, 1);
        check(lamp_n, 1);
        // aim low wakes, then drives the aim leds in standby
        aim_n <= 1'b0;
        tick(2);
        check(sleep, 0);
        check(aim, 1);
        aim_n <= 1'b1;
        tick(2);
        check(aim, 0);
        apb(1, OFS_CTRL, 32'h0);
        vbus <= 1'($urandom_range(0, 1));
        apb(0, OFS_STAT, 0);
        check(rdat[ST_DL], !dl);
        check(rdat[ST_VBUS], vbus);
        // random control words, sleep_en kept off
        for (int i = 0; i < 4; i++) begin
            v = $urandom & 32'h1e;
            apb(1, OFS_CTRL, v);
            apb(0, OFS_CTRL, 0);
            check(rdat, v);
            check(lamp_n, !v[2]);
            check(light_n, !v[3]);
        end
        // scan overrides the aim pin with the internal bit
        trig_n <= 1'b0;
        tick(2);
        check(scan, 1);
        check(aim, v[1]);
        apb(0, OFS_STAT, 0);
        check(rdat[ST_SCAN], 1);
        check(rdat[ST_TRIG], 1);
        trig_n <= 1'b1;
        tick(2);
        check(scan, 0);
        // buzzer: period 10, random duty, count highs over two periods
        for (int i = 0; i < 2; i++) begin
            d = $urandom_range(1, 9);
            apb(1, OFS_BUZ, {d[15:0], 16'h0009});
            apb(1, OFS_CTRL, 32'h10);
            tick(12);
            cnt = 0;
            repeat (20) begin
                @(posedge core_clk_i);
                cnt = cnt + buz;
            end
            check(cnt, buz_highs(d, 2));
        end
        apb(0, 8'h14, 0);
        check(rerr, 1);
        check(rdat, 0);
        // receive one byte from the host
        v = $urandom & 32'hff;
        i_host.send(v[7:0]);
        apb(0, OFS_STAT, 0);
        check(rdat[ST_RXV], 1);
        apb(0, OFS_RXD, 0);
        check(rdat[7:0], v[7:0]);
        apb(0, OFS_STAT, 0);
        check(rdat[ST_RXV], 0);
        // fill the fifo while the host withholds permission
        for (int i = 0; i < 16; i++) begin
            b[i] = 8'($urandom);
            apb(1, OFS_TXD, {24'h0, b[i]});
        end
        apb(0, OFS_STAT, 0);
        check(rdat[ST_FULL], 1);
        check(rdat[ST_EMPTY], 0);
        check(rts, 1);
        check(txd, 1);
        allow <= 1'b1;
        n = 0;
        while (i_host.got.size() < 2 && n < 30000) begin
            @(posedge core_clk_i);
            n++;
        end
        check(i_host.got.size(), 2);
        check(i_host.got[0], b[0]);
        check(i_host.got[1], b[1]);
        // second reset mid-frame empties the path
        allow <= 1'b0;
        tick(2);
        rst_n_i <= 1'b0;
        tick(2);
        check(rts, 0);
        check(txd, 1);
        rst_n_i <= 1'b1;
        tick(2);
        check(sleep, 1);
        apb(0, OFS_STAT, 0);
        check(rdat[ST_EMPTY], 1);
        allow <= 1'b1;
        tick(3);
        check(sleep, 0);
        allow <= 1'b0;
        tick(40);
        check(sleep, 0);
        tick(30);
        check(sleep, 1);
        check(lamp_n, 1);
        summarize();
    end
endmodule : scan_engine_host_pins_bench
